// ---- verilog/pecl_channel_clock_dividers.v ----
// two channel dividers with their register file on AXI4-Lite and the
// routing of two differential output pairs.
// assumes all inputs are synchronous to ref_clk; the source select code
// comes from a register outside this block.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "pecl_div_defs_defs.vh"

module pecl_channel_clock_dividers (
	input  wire        ref_clk,
	input  wire        resetn,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        distClk,
	input  wire        internalOscillator,
	input  wire        extClk,
	input  wire [1:0]  sourceSelect,
	input  wire        alignPulse,
	output reg         pairAOutP,
	output reg         pairAOutN,
	output reg         pairBOutP,
	output reg         pairBOutN
);

	// ------------------------------------------------------------------
	// register file
	// ------------------------------------------------------------------
	reg  [7:0] div0Len;
	reg  [7:0] div0Ctl;
	reg  [7:0] div0Route;
	reg  [7:0] div1Len;
	reg  [7:0] div1Ctl;
	reg  [7:0] div1Route;

	// ------------------------------------------------------------------
	// write channel state
	// ------------------------------------------------------------------
	reg  [11:0] wrAddr;
	reg         wrAddrHeld;
	reg  [7:0]  wrData;
	reg         wrStrb;
	reg         wrDataHeld;
	wire [9:0]  wrIdx;
	wire        wrGo;
	reg         wrHit;

	// ------------------------------------------------------------------
	// routing state per pair
	// ------------------------------------------------------------------
	localparam RT_DIV = 3'b001;
	localparam RT_OSC = 3'b010;
	localparam RT_EXT = 3'b100;

	reg  [2:0] routeA;
	reg  [2:0] routeB;
	reg  [2:0] next_routeA;
	reg  [2:0] next_routeB;
	wire       div0Out;
	wire       div1Out;
	wire       div0Running;
	wire       div1Running;
	reg        levelA;
	reg        levelB;

	// ------------------------------------------------------------------
	// read channel state
	// ------------------------------------------------------------------
	wire [9:0] rdIdx;
	reg  [7:0] rdByte;
	reg        rdHit;

	assign wrIdx = wrAddr[11:2];
	assign wrGo  = wrAddrHeld & wrDataHeld & ~s_axi_bvalid;
	assign rdIdx = s_axi_araddr[11:2];

	// ------------------------------------------------------------------
	// write address and data capture, either order
	// ------------------------------------------------------------------
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			wrAddr        <= 12'h000;
			wrAddrHeld    <= 1'b0;
			wrData        <= 8'h00;
			wrStrb        <= 1'b0;
			wrDataHeld    <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wrAddr        <= s_axi_awaddr;
				wrAddrHeld    <= 1'b1;
				s_axi_awready <= 1'b0;
			end else if (wrGo) begin
				wrAddrHeld <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wrData       <= s_axi_wdata[7:0];
				wrStrb       <= s_axi_wstrb[0];
				wrDataHeld   <= 1'b1;
				s_axi_wready <= 1'b0;
			end else if (wrGo) begin
				wrDataHeld <= 1'b0;
			end
			// accept the next write only once the response is taken
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// address decode for writes
	// ------------------------------------------------------------------
	always @* begin
		case (wrIdx)
		`DIV0_LEN_IDX:   wrHit = 1'b1;
		`DIV0_CTL_IDX:   wrHit = 1'b1;
		`DIV0_ROUTE_IDX: wrHit = 1'b1;
		`DIV_STATUS_IDX: wrHit = 1'b1;
		`DIV1_LEN_IDX:   wrHit = 1'b1;
		`DIV1_CTL_IDX:   wrHit = 1'b1;
		`DIV1_ROUTE_IDX: wrHit = 1'b1;
		default:         wrHit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// register update and write response
	// ------------------------------------------------------------------
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			div0Len      <= `DIV0_LEN_RST; // R14
			div0Ctl      <= `DIV0_CTL_RST; // R4
			div0Route    <= `ROUTE_RST; // R13
			div1Len      <= `DIV1_LEN_RST; // R14
			div1Ctl      <= `DIV1_CTL_RST; // R5
			div1Route    <= `ROUTE_RST; // R13
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else begin
			if (wrGo) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
				// only byte lane 0 carries register bits
				if (wrStrb) begin
					case (wrIdx)
					`DIV0_LEN_IDX:   div0Len   <= wrData;
					`DIV0_CTL_IDX:   div0Ctl   <= wrData;
					`DIV0_ROUTE_IDX: div0Route <= {6'h00, wrData[1:0]};
					`DIV1_LEN_IDX:   div1Len   <= wrData;
					`DIV1_CTL_IDX:   div1Ctl   <= wrData;
					`DIV1_ROUTE_IDX: div1Route <= {6'h00, wrData[1:0]};
					default: begin
					end
					endcase
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// read decode; status shows live divider and routing state
	// ------------------------------------------------------------------
	always @* begin
		rdHit = 1'b1;
		case (rdIdx)
		`DIV0_LEN_IDX:   rdByte = div0Len;
		`DIV0_CTL_IDX:   rdByte = div0Ctl;
		`DIV0_ROUTE_IDX: rdByte = div0Route;
		`DIV1_LEN_IDX:   rdByte = div1Len;
		`DIV1_CTL_IDX:   rdByte = div1Ctl;
		`DIV1_ROUTE_IDX: rdByte = div1Route;
		`DIV_STATUS_IDX: rdByte = {routeB[1:0], routeA[1:0], levelB, levelA,
		                           div1Running, div0Running};
		default: begin
			rdByte = 8'h00;
			rdHit  = 1'b0;
		end
		endcase
	end

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {24'h000000, rdByte};
				s_axi_rresp   <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// the two dividers
	// ------------------------------------------------------------------
	pecl_divider u_div0 (
		.ref_clk     (ref_clk),
		.resetn      (resetn),
		.highCnt     (div0Len[`LEN_HIGH_HI:`LEN_HIGH_LO]),
		.lowCnt      (div0Len[`LEN_LOW_HI:`LEN_LOW_LO]),
		.phase       (div0Ctl[`CTL_PHASE_HI:`CTL_PHASE_LO]), // R10
		.startHigh   (div0Ctl[`CTL_START]),
		.bypass      (div0Ctl[`CTL_BYPASS]),
		.ignoreAlign (div0Ctl[`CTL_NOALIGN]), // R6
		.forceHigh   (div0Ctl[`CTL_FORCE]),
		.alignPulse  (alignPulse),
		.clkIn       (distClk),
		.divOut      (div0Out),
		.running     (div0Running)
	);

	pecl_divider u_div1 (
		.ref_clk     (ref_clk),
		.resetn      (resetn),
		.highCnt     (div1Len[`LEN_HIGH_HI:`LEN_HIGH_LO]),
		.lowCnt      (div1Len[`LEN_LOW_HI:`LEN_LOW_LO]),
		.phase       (div1Ctl[`CTL_PHASE_HI:`CTL_PHASE_LO]), // R10
		.startHigh   (div1Ctl[`CTL_START]),
		.bypass      (div1Ctl[`CTL_BYPASS]),
		.ignoreAlign (div1Ctl[`CTL_NOALIGN]), // R6
		.forceHigh   (div1Ctl[`CTL_FORCE]),
		.alignPulse  (alignPulse),
		.clkIn       (distClk),
		.divOut      (div1Out),
		.running     (div1Running)
	);

	// ------------------------------------------------------------------
	// direct-route selection; code 01 keeps the present source
	// ------------------------------------------------------------------
	always @* begin
		next_routeA = routeA;
		if (!div0Route[`ROUTE_DIRECT]) begin
			next_routeA = RT_DIV; // R11
		end else begin
			case (sourceSelect)
			`SRC_OSC: next_routeA = RT_OSC; // R11
			`SRC_EXT: next_routeA = RT_EXT; // R11
			default:  next_routeA = routeA;
			endcase
		end
	end

	always @* begin
		next_routeB = routeB;
		if (!div1Route[`ROUTE_DIRECT]) begin
			next_routeB = RT_DIV; // R12
		end else begin
			case (sourceSelect)
			`SRC_OSC: next_routeB = RT_OSC; // R12
			`SRC_EXT: next_routeB = RT_EXT; // R12
			default:  next_routeB = routeB;
			endcase
		end
	end

	always @* begin
		case (routeA)
		RT_OSC:  levelA = internalOscillator;
		RT_EXT:  levelA = extClk;
		default: levelA = div0Out;
		endcase
	end

	always @* begin
		case (routeB)
		RT_OSC:  levelB = internalOscillator;
		RT_EXT:  levelB = extClk;
		default: levelB = div1Out;
		endcase
	end

	// ------------------------------------------------------------------
	// output pairs; the complement is registered with the true side so
	// both legs change on the same edge
	// ------------------------------------------------------------------
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			routeA    <= RT_DIV;
			routeB    <= RT_DIV;
			pairAOutP <= 1'b0;
			pairAOutN <= 1'b1;
			pairBOutP <= 1'b0;
			pairBOutN <= 1'b1;
		end else begin
			routeA    <= next_routeA;
			routeB    <= next_routeB;
			pairAOutP <= levelA;
			pairAOutN <= ~levelA;
			pairBOutP <= levelB;
			pairBOutN <= ~levelB;
		end
	end

endmodule

`default_nettype wire

// ---- verilog/pecl_div_defs_defs.vh ----
// register offsets, field positions, reset values and bus codes for the two
// channel clock dividers; included by the top design file and the bench.
// assumes a 10 MHz ref_clk and an AXI4-Lite master with 32-bit data.
//
// Function
// R1: low time is low-count field plus one
// R2: high time is high-count field plus one
// R3: bypass bit idles counter, passes input clock
// R4: first divider resets bypassed
// R5: second divider resets counting
// R6: alignment-ignore bit, bit 6, resets zero
// R7: force level bit 5, resets low
// R8: software sets ignore bit to force high
// R9: start level bit 4, resets low
// R10: phase offset field bits 3..0, resets zero
// R11: pair A direct route by source select
// R12: pair B direct route, same codes
// R13: routing bit 0 disables duty correction; the design only stores the bit
// R14: both count fields reset to zero
// R15: period is high plus low; phase delays start
// R16: alignment pulse restarts dividers at start level
`ifndef PECL_DIV_DEFS_DEFS_VH
`define PECL_DIV_DEFS_DEFS_VH

// ----------------------------------------------------------------------
// register indices; byte address is four times the index
// ----------------------------------------------------------------------
`define DIV0_LEN_IDX    10'h190
`define DIV0_CTL_IDX    10'h191
`define DIV0_ROUTE_IDX  10'h192
`define DIV_STATUS_IDX  10'h193
`define DIV1_LEN_IDX    10'h196
`define DIV1_CTL_IDX    10'h197
`define DIV1_ROUTE_IDX  10'h198

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LEN_LOW_HI      7
`define LEN_LOW_LO      4
`define LEN_HIGH_HI     3
`define LEN_HIGH_LO     0
`define CTL_BYPASS      7
`define CTL_NOALIGN     6
`define CTL_FORCE       5
`define CTL_START       4
`define CTL_PHASE_HI    3
`define CTL_PHASE_LO    0
`define ROUTE_DIRECT    1
`define ROUTE_DUTYOFF   0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DIV0_LEN_RST    8'h00
`define DIV0_CTL_RST    8'h80
`define DIV1_LEN_RST    8'h00
`define DIV1_CTL_RST    8'h00
`define ROUTE_RST       8'h00

// ----------------------------------------------------------------------
// source select codes and bus responses
// ----------------------------------------------------------------------
`define SRC_EXT         2'h0
`define SRC_NONE        2'h1
`define SRC_OSC         2'h2
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ---- verilog/pecl_divider.v ----
// one programmable divider counting ref_clk cycles as its input cycles.
// assumes clkIn is a level synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none

module pecl_divider (
	input  wire       ref_clk,
	input  wire       resetn,
	input  wire [3:0] highCnt,
	input  wire [3:0] lowCnt,
	input  wire [3:0] phase,
	input  wire       startHigh,
	input  wire       bypass,
	input  wire       ignoreAlign,
	input  wire       forceHigh,
	input  wire       alignPulse,
	input  wire       clkIn,
	output reg        divOut,
	output wire       running
);

	localparam ST_OFF  = 4'b0001;
	localparam ST_WAIT = 4'b0010;
	localparam ST_HIGH = 4'b0100;
	localparam ST_LOW  = 4'b1000;

	reg  [3:0] state;
	reg  [3:0] cnt;
	wire       restart;

	assign restart = alignPulse & ~ignoreAlign; // R16
	assign running = (state != ST_OFF);

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state  <= ST_OFF;
			cnt    <= 4'h0;
			divOut <= 1'b0;
		end else if (bypass) begin
			state  <= ST_OFF; // R3
			cnt    <= 4'h0;
			divOut <= clkIn; // R3
		end else if (forceHigh & ignoreAlign) begin
			state  <= ST_OFF; // R8
			cnt    <= 4'h0;
			divOut <= 1'b1; // R7
		end else if (restart || state == ST_OFF) begin
			divOut <= startHigh; // R9
			if (phase != 4'h0) begin
				state <= ST_WAIT; // R15
				cnt   <= phase - 4'h1;
			end else begin
				state <= startHigh ? ST_HIGH : ST_LOW;
				cnt   <= startHigh ? highCnt : lowCnt;
			end
		end else begin
			case (state)
			ST_WAIT: begin
				if (cnt == 4'h0) begin
					state <= startHigh ? ST_HIGH : ST_LOW;
					cnt   <= startHigh ? highCnt : lowCnt;
				end else begin
					cnt <= cnt - 4'h1;
				end
			end
			ST_HIGH: begin
				if (cnt == 4'h0) begin
					state  <= ST_LOW; // R15
					cnt    <= lowCnt; // R1
					divOut <= 1'b0;
				end else begin
					cnt <= cnt - 4'h1; // R2
				end
			end
			ST_LOW: begin
				if (cnt == 4'h0) begin
					state  <= ST_HIGH;
					cnt    <= highCnt; // R2
					divOut <= 1'b1;
				end else begin
					cnt <= cnt - 4'h1; // R1
				end
			end
			default: begin
				state  <= ST_OFF;
				cnt    <= 4'h0;
				divOut <= 1'b0;
			end
			endcase
		end
	end

endmodule

`default_nettype wire

// ---- verification/pecl_div_assertions.sv ----
// concurrent checks on the bus handshakes and output pairs of the divider block.
// assumes it is bound to pecl_channel_clock_dividers and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module pecl_div_checker (
	input wire logic        ref_clk,
	input wire logic        resetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        pairAOutP,
	input wire logic        pairAOutN,
	input wire logic        pairBOutP,
	input wire logic        pairBOutN
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_pair_a_diff: assert property (pairAOutN == !pairAOutP)
		else $error("pair A legs not complementary");
	a_pair_b_diff: assert property (pairBOutN == !pairBOutP)
		else $error("pair B legs not complementary");
	// both halves are parked for a cycle before the response is raised
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_read_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_read_release: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid && s_axi_arready) else $error("read slot not freed");

	c_write_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_read_done: cover property (s_axi_rvalid && s_axi_rready);
	c_pair_b_rise: cover property ($rose(pairBOutP));
endmodule

bind pecl_channel_clock_dividers pecl_div_checker chk (.ref_clk, .resetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pairAOutP,
	.pairAOutN, .pairBOutP, .pairBOutN);
`default_nettype wire

// ---- verification/pecl_channel_clock_dividers_tb.sv ----
// self-checking bench: registers over AXI4-Lite, pair outputs against sources.
// assumes the design files and the checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "pecl_div_defs_defs.vh"

module pecl_channel_clock_dividers_tb;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        distClk = 1'b0, internalOscillator = 1'b0, extClk = 1'b0;
	logic [1:0]  sourceSelect = `SRC_NONE;
	logic        alignPulse = 1'b0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         pairAOutP, pairAOutN, pairBOutP, pairBOutN;
	int          errors = 0, checks_done = 0, hi, lo, k, p;
	logic [3:0]  cnt = 4'h0;
	logic [3:0]  hist [0:1];
	logic [31:0] d;
	logic [1:0]  r;
	logic [9:0]  idxs [6] = '{`DIV0_LEN_IDX, `DIV0_CTL_IDX, `DIV0_ROUTE_IDX, `DIV1_LEN_IDX,
		`DIV1_CTL_IDX, `DIV1_ROUTE_IDX};
	logic [7:0]  rsts [6] = '{`DIV0_LEN_RST, `DIV0_CTL_RST, `ROUTE_RST, `DIV1_LEN_RST,
		`DIV1_CTL_RST, `ROUTE_RST};
	logic [7:0]  lens [4] = '{8'h00, 8'h21, 8'hf0, 8'h3a};

	pecl_channel_clock_dividers uut (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .distClk, .internalOscillator,
		.extClk, .sourceSelect, .alignPulse, .pairAOutP, .pairAOutN, .pairBOutP, .pairBOutN);

	// ----------------------------------------------------------------
	// clock and source patterns; hist keeps {1, osc, ext, dist} per edge
	// ----------------------------------------------------------------
	always #50 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cnt <= cnt + 4'h1;
		internalOscillator <= cnt[1];
		extClk <= cnt[2];
		distClk <= cnt[0] ^ cnt[2];
		hist[0] <= {1'b1, internalOscillator, extClk, distClk};
		hist[1] <= hist[0];
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] v, output logic [1:0] rs);
		int n;
		@(posedge ref_clk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
			// late bready keeps the response waiting for a cycle
			if (n >= 2) s_axi_bready <= 1'b1;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		chk("write wait", 32'h0, n / 50);
	endtask

	task automatic rd(input logic [9:0] idx, output logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge ref_clk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
			// late rready keeps the read data waiting for a cycle
			if (n >= 1) s_axi_rready <= 1'b1;
		end
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk("read wait", 32'h0, n / 50);
	endtask

	// pair pin must track source bit src delayed by d+1 edges
	task automatic follow(input int b, input logic [1:0] sel, input int src, input int d);
		@(posedge ref_clk);
		sourceSelect <= sel;
		repeat (4) @(negedge ref_clk);
		repeat (8) begin
			@(negedge ref_clk);
			chk("pair level", hist[d][src], b ? pairBOutP : pairAOutP);
		end
	endtask

	task automatic run(output int n);
		logic v;
		v = pairBOutP;
		for (n = 0; n < 40 && pairBOutP === v; n++) @(negedge ref_clk);
	endtask

	// settle past any old period, then time one full high and low phase
	task automatic measure(output int h, output int l);
		int n;
		repeat (40) @(negedge ref_clk);
		for (n = 0; n < 40 && pairBOutP !== 1'b0; n++) @(negedge ref_clk);
		for (n = 0; n < 40 && pairBOutP !== 1'b1; n++) @(negedge ref_clk);
		run(h);
		run(l);
	endtask

	task automatic end_of_test;
		if (errors == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		#1000000;
		errors++;
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(idxs[i], d, r);
			chk("reset value", {24'h0, rsts[i]}, d);
		end
		rd(10'h194, d, r);
		chk("unmapped read", {30'h0, `RESP_SLVERR}, {30'h0, r});
		wr(10'h194, 8'h5a, r);
		chk("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, r});
		wr(`DIV1_ROUTE_IDX, 8'h01, r);
		rd(`DIV1_ROUTE_IDX, d, r);
		chk("duty bit", 32'h1, d);
		s_axi_wstrb <= 4'he;
		wr(`DIV1_ROUTE_IDX, 8'h00, r);
		s_axi_wstrb <= 4'hf;
		chk("masked write resp", {30'h0, `RESP_OKAY}, {30'h0, r});
		rd(`DIV1_ROUTE_IDX, d, r);
		chk("masked write", 32'h1, d);
		follow(0, `SRC_NONE, 0, 1);
		for (int i = 0; i < 4; i++) begin
			wr(`DIV1_LEN_IDX, lens[i], r);
			measure(hi, lo);
			chk("high time", lens[i][3:0] + 1, hi);
			chk("low time", lens[i][7:4] + 1, lo);
		end
		wr(`DIV1_CTL_IDX, 8'h80, r);
		follow(1, `SRC_NONE, 0, 1);
		wr(`DIV1_CTL_IDX, 8'h60, r);
		follow(1, `SRC_NONE, 3, 0);
		wr(`DIV1_CTL_IDX, 8'h20, r);
		measure(hi, lo);
		chk("unforced high", 32'd11, hi);
		wr(`DIV1_LEN_IDX, 8'h00, r);
		wr(`DIV1_CTL_IDX, 8'h10, r);
		alignPulse <= 1'b1;
		follow(1, `SRC_NONE, 3, 0);
		wr(`DIV1_CTL_IDX, 8'h50, r);
		measure(hi, lo);
		chk("ignored align", 32'd2, hi + lo);
		alignPulse <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			wr(`DIV1_LEN_IDX, i ? 8'h14 : 8'h21, r);
			wr(`DIV1_CTL_IDX, i ? 8'h02 : 8'h13, r);
			@(posedge ref_clk);
			alignPulse <= 1'b1;
			@(posedge ref_clk);
			alignPulse <= 1'b0;
			repeat (2) @(negedge ref_clk);
			chk("start level", i ? 32'h0 : 32'h1, pairBOutP);
			run(k);
			chk("first phase", i ? 32'd4 : 32'd5, k);
		end
		for (p = 0; p < 2; p++) begin
			wr(p ? `DIV1_ROUTE_IDX : `DIV0_ROUTE_IDX, 8'h02, r);
			follow(p, `SRC_OSC, 2, 0);
			follow(p, `SRC_EXT, 1, 0);
			follow(p, `SRC_NONE, 1, 0);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
